// ---- core/fan_regs_defs.vh ----
`ifndef FAN_REGS_DEFS_VH
`define FAN_REGS_DEFS_VH

// Register offsets
`define OFS_LOCAL_TEMP_HIGH_BYTE  8'h0a
`define OFS_REMOTE_TEMP_HIGH_BYTE 8'h0b
`define OFS_LOCAL_UPPER_LIMIT     8'h14
`define OFS_LOCAL_LOWER_LIMIT     8'h15
`define OFS_LOCAL_OVERHEAT_LIMIT  8'h16
`define OFS_REMOTE_UPPER_LIMIT    8'h18
`define OFS_REMOTE_LOWER_LIMIT    8'h19
`define OFS_REMOTE_OVERHEAT_LIMIT 8'h1a
`define OFS_LOCAL_CRITICAL_LIMIT  8'h1b
`define OFS_PASSIVE_COOLING_LIMIT 8'h1c
`define OFS_REMOTE_CRITICAL_LIMIT 8'h1d
`define OFS_FAN_TRAITS            8'h20
`define OFS_COOL_DUTY_SETTING     8'h21

// Reset values
`define RST_TEMP_HIGH_BYTE        8'h80
`define RST_LOCAL_UPPER_LIMIT     8'h3c
`define RST_LOCAL_LOWER_LIMIT     8'h00
`define RST_LOCAL_OVERHEAT_LIMIT  8'h46
`define RST_REMOTE_UPPER_LIMIT    8'h50
`define RST_REMOTE_LOWER_LIMIT    8'h00
`define RST_REMOTE_OVERHEAT_LIMIT 8'h64
`define RST_LOCAL_CRITICAL_LIMIT  8'h50
`define RST_PASSIVE_COOLING_LIMIT 8'h00
`define RST_REMOTE_CRITICAL_LIMIT 8'h69
`define RST_FAN_TRAITS            8'h1d
`define RST_COOL_DUTY_SETTING     8'h55

// Field positions
`define PASSIVE_COOLING_MASK      8'h3f
`define FAN_TRAITS_MASK           8'hbf
`define SPIN_DISABLE_BIT          7
`define PWM_FREQ_MSB              5
`define PWM_FREQ_LSB              3
`define SPINUP_TIME_MSB           2
`define SPINUP_TIME_LSB           0

// Serial target address
`define TARGET_ADDR               7'h18

`endif

// ---- core/smbus_line_sync.v ----
`timescale 1ns/1ns
module smbus_line_sync (
   input wire clk_i,
   input wire arst_n_i,
   input wire scl_i,
   input wire sda_i,
   output reg scl_rise_o,
   output reg scl_fall_o,
   output reg start_o,
   output reg stop_o,
   output reg sda_lvl_o
);
   reg [2:0] scl_sh_r;
   reg [2:0] sda_sh_r;
   reg scl_lvl_r;

   // A level counts only when the second and third stages agree
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         scl_sh_r <= 3'h7;
         sda_sh_r <= 3'h7;
         scl_lvl_r <= 1'b1;
         sda_lvl_o <= 1'b1;
         scl_rise_o <= 1'b0;
         scl_fall_o <= 1'b0;
         start_o <= 1'b0;
         stop_o <= 1'b0;
      end else begin
         scl_sh_r <= {scl_sh_r[1:0], scl_i};
         sda_sh_r <= {sda_sh_r[1:0], sda_i};
         scl_rise_o <= 1'b0;
         scl_fall_o <= 1'b0;
         start_o <= 1'b0;
         stop_o <= 1'b0;
         if (scl_sh_r[1] == scl_sh_r[2]) begin
            scl_lvl_r <= scl_sh_r[2];
            scl_rise_o <= scl_sh_r[2] & ~scl_lvl_r;
            scl_fall_o <= ~scl_sh_r[2] & scl_lvl_r;
         end
         if (sda_sh_r[1] == sda_sh_r[2]) begin
            sda_lvl_o <= sda_sh_r[2];
            start_o <= scl_lvl_r & sda_lvl_o & ~sda_sh_r[2];
            stop_o <= scl_lvl_r & ~sda_lvl_o & sda_sh_r[2];
         end
      end
   end
endmodule

// ---- core/limit_compare.v ----
`timescale 1ns/1ns
module limit_compare (
   input wire [10:0] reading_i,
   input wire [7:0] limit_i,
   output wire at_or_above_o,
   output wire below_o
);
   // Limit holds the top eight bits; its three low bits count as zero
   wire signed [10:0] rd_s = reading_i;
   wire signed [10:0] lim_s = {limit_i, 3'h0};

   assign at_or_above_o = (rd_s >= lim_s);
   assign below_o = (rd_s < lim_s);
endmodule

// ---- core/temp_limit_fan_register_bank.v ----
`timescale 1ns/1ns
`include "fan_regs_defs.vh"

module temp_limit_fan_register_bank (
   input wire clk_i,
   input wire arst_n_i,
   input wire scl_i,
   input wire sda_i,
   output wire sda_o,
   output wire sda_oe_n_o,
   input wire alert_i,
   output wire alert_o,
   output wire alert_oe_n_o,
   input wire [10:0] local_temp_i,
   input wire [10:0] remote_temp_i,
   input wire temp_valid_i,
   input wire global_int_en_i,
   input wire local_crit_int_en_i,
   input wire remote_crit_int_en_i,
   input wire flag_clear_i,
   input wire auto_fan_mode_i,
   input wire cool_zone_i,
   input wire [7:0] loop_duty_i,
   output reg [7:0] duty_value_o,
   output reg local_critical_flag_o,
   output reg remote_critical_flag_o,
   output reg overtemp_output_n_o,
   output reg local_out_of_range_o,
   output reg remote_out_of_range_o,
   output reg local_overheat_o,
   output reg remote_overheat_o,
   output wire [5:0] passive_cooling_o,
   output wire spin_disable_o,
   output wire [2:0] pwm_freq_sel_o,
   output wire [2:0] spinup_time_o
);
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_ADDR = 3'h1;
   localparam [2:0] ST_PTR = 3'h2;
   localparam [2:0] ST_WDATA = 3'h3;
   localparam [2:0] ST_ACK = 3'h4;
   localparam [2:0] ST_READ = 3'h5;
   localparam [2:0] ST_RACK = 3'h6;

   wire scl_rise;
   wire scl_fall;
   wire bus_start;
   wire bus_stop;
   wire sda_lvl;

   reg [2:0] state_r;
   reg [2:0] after_ack_r;
   reg [2:0] bit_cnt_r;
   reg [7:0] shift_r;
   reg [7:0] ptr_r;
   reg got_byte_r;
   reg host_ack_r;
   reg sda_drive_r;
   reg [7:0] rd_data;
   wire wr_now;

   reg [10:0] local_temp_r;
   reg [10:0] remote_temp_r;
   reg [7:0] local_upper_limit_r;
   reg [7:0] local_lower_limit_r;
   reg [7:0] local_overheat_limit_r;
   reg [7:0] remote_upper_limit_r;
   reg [7:0] remote_lower_limit_r;
   reg [7:0] remote_overheat_limit_r;
   reg [7:0] local_critical_limit_r;
   reg [7:0] passive_cooling_limit_r;
   reg [7:0] remote_critical_limit_r;
   reg [7:0] fan_traits_r;
   reg [7:0] cool_duty_setting_r;

   wire local_crit_ge;
   wire remote_crit_ge;
   wire local_hi_ge;
   wire local_lo_lt;
   wire local_th_ge;
   wire remote_hi_ge;
   wire remote_lo_lt;
   wire remote_th_ge;
   wire unused_lt0;
   wire unused_lt1;
   wire unused_lt2;
   wire unused_lt3;
   wire unused_lt4;
   wire unused_ge0;
   wire unused_ge1;
   wire local_reading_top_bit;
   wire remote_lower_limit_top_bit;
   wire cool_duty_top_bit;

   ////////////////////////////////////////////////////////////////////////////
   // Serial line conditioning

   smbus_line_sync u_sync (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .scl_rise_o(scl_rise),
      .scl_fall_o(scl_fall),
      .start_o(bus_start),
      .stop_o(bus_stop),
      .sda_lvl_o(sda_lvl)
   );

   // Open-drain: only ever pull low
   assign sda_o = 1'b0;
   assign sda_oe_n_o = ~sda_drive_r;

   ////////////////////////////////////////////////////////////////////////////
   // Byte protocol: address, pointer, data; reads return the pointed register

   assign wr_now = (state_r == ST_WDATA) && scl_fall && got_byte_r && !bus_start && !bus_stop;

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_r <= ST_IDLE;
         after_ack_r <= ST_IDLE;
         bit_cnt_r <= 3'h0;
         shift_r <= 8'h00;
         ptr_r <= 8'h00;
         got_byte_r <= 1'b0;
         host_ack_r <= 1'b0;
         sda_drive_r <= 1'b0;
      end else if (bus_stop) begin
         state_r <= ST_IDLE;
         got_byte_r <= 1'b0;
         sda_drive_r <= 1'b0;
      end else if (bus_start) begin
         // Pointer survives a repeated start so a read follows a pointer write
         state_r <= ST_ADDR;
         bit_cnt_r <= 3'h0;
         got_byte_r <= 1'b0;
         sda_drive_r <= 1'b0;
      end else begin
         case (state_r)
            ST_ADDR, ST_PTR, ST_WDATA: begin
               if (scl_rise) begin
                  shift_r <= {shift_r[6:0], sda_lvl};
                  bit_cnt_r <= bit_cnt_r + 3'h1;
                  if (bit_cnt_r == 3'h7) begin
                     got_byte_r <= 1'b1;
                  end
               end else if (scl_fall && got_byte_r) begin
                  got_byte_r <= 1'b0;
                  if (state_r == ST_ADDR) begin
                     if (shift_r[7:1] == `TARGET_ADDR) begin
                        sda_drive_r <= 1'b1;
                        state_r <= ST_ACK;
                        after_ack_r <= shift_r[0] ? ST_READ : ST_PTR;
                     end else begin
                        state_r <= ST_IDLE;
                     end
                  end else begin
                     if (state_r == ST_PTR) begin
                        ptr_r <= shift_r;
                     end
                     sda_drive_r <= 1'b1;
                     state_r <= ST_ACK;
                     after_ack_r <= ST_WDATA;
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  bit_cnt_r <= 3'h0;
                  state_r <= after_ack_r;
                  if (after_ack_r == ST_READ) begin
                     shift_r <= rd_data;
                     sda_drive_r <= ~rd_data[7];
                  end else begin
                     sda_drive_r <= 1'b0;
                  end
               end
            end
            ST_READ: begin
               if (scl_fall) begin
                  bit_cnt_r <= bit_cnt_r + 3'h1;
                  if (bit_cnt_r == 3'h7) begin
                     sda_drive_r <= 1'b0;
                     state_r <= ST_RACK;
                  end else begin
                     shift_r <= {shift_r[6:0], 1'b0};
                     sda_drive_r <= ~shift_r[6];
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  host_ack_r <= ~sda_lvl;
               end else if (scl_fall) begin
                  // Host acknowledge asks for the same register again
                  if (host_ack_r) begin
                     bit_cnt_r <= 3'h0;
                     shift_r <= rd_data;
                     sda_drive_r <= ~rd_data[7];
                     state_r <= ST_READ;
                  end else begin
                     state_r <= ST_IDLE;
                  end
               end
            end
            default: begin
               state_r <= ST_IDLE;
               sda_drive_r <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register file

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         local_upper_limit_r <= `RST_LOCAL_UPPER_LIMIT;
         local_lower_limit_r <= `RST_LOCAL_LOWER_LIMIT;
         local_overheat_limit_r <= `RST_LOCAL_OVERHEAT_LIMIT;
         remote_upper_limit_r <= `RST_REMOTE_UPPER_LIMIT;
         remote_lower_limit_r <= `RST_REMOTE_LOWER_LIMIT;
         remote_overheat_limit_r <= `RST_REMOTE_OVERHEAT_LIMIT;
         local_critical_limit_r <= `RST_LOCAL_CRITICAL_LIMIT;
         passive_cooling_limit_r <= `RST_PASSIVE_COOLING_LIMIT;
         remote_critical_limit_r <= `RST_REMOTE_CRITICAL_LIMIT;
         fan_traits_r <= `RST_FAN_TRAITS;
         cool_duty_setting_r <= `RST_COOL_DUTY_SETTING;
      end else if (wr_now) begin
         // Read-only and reserved offsets fall through untouched
         if (ptr_r == `OFS_LOCAL_UPPER_LIMIT) begin
            local_upper_limit_r <= shift_r;
         end else if (ptr_r == `OFS_LOCAL_LOWER_LIMIT) begin
            local_lower_limit_r <= shift_r;
         end else if (ptr_r == `OFS_LOCAL_OVERHEAT_LIMIT) begin
            local_overheat_limit_r <= shift_r;
         end else if (ptr_r == `OFS_REMOTE_UPPER_LIMIT) begin
            remote_upper_limit_r <= shift_r;
         end else if (ptr_r == `OFS_REMOTE_LOWER_LIMIT) begin
            remote_lower_limit_r <= shift_r;
         end else if (ptr_r == `OFS_REMOTE_OVERHEAT_LIMIT) begin
            remote_overheat_limit_r <= shift_r;
         end else if (ptr_r == `OFS_LOCAL_CRITICAL_LIMIT) begin
            local_critical_limit_r <= shift_r;
         end else if (ptr_r == `OFS_PASSIVE_COOLING_LIMIT) begin
            passive_cooling_limit_r <= shift_r & `PASSIVE_COOLING_MASK;
         end else if (ptr_r == `OFS_REMOTE_CRITICAL_LIMIT) begin
            remote_critical_limit_r <= shift_r;
         end else if (ptr_r == `OFS_FAN_TRAITS) begin
            fan_traits_r <= shift_r & `FAN_TRAITS_MASK;
         end else if (ptr_r == `OFS_COOL_DUTY_SETTING) begin
            cool_duty_setting_r <= shift_r;
         end
      end
   end

   always @* begin
      if (ptr_r == `OFS_LOCAL_TEMP_HIGH_BYTE) begin
         rd_data = local_temp_r[10:3];
      end else if (ptr_r == `OFS_REMOTE_TEMP_HIGH_BYTE) begin
         rd_data = remote_temp_r[10:3];
      end else if (ptr_r == `OFS_LOCAL_UPPER_LIMIT) begin
         rd_data = local_upper_limit_r;
      end else if (ptr_r == `OFS_LOCAL_LOWER_LIMIT) begin
         rd_data = local_lower_limit_r;
      end else if (ptr_r == `OFS_LOCAL_OVERHEAT_LIMIT) begin
         rd_data = local_overheat_limit_r;
      end else if (ptr_r == `OFS_REMOTE_UPPER_LIMIT) begin
         rd_data = remote_upper_limit_r;
      end else if (ptr_r == `OFS_REMOTE_LOWER_LIMIT) begin
         rd_data = remote_lower_limit_r;
      end else if (ptr_r == `OFS_REMOTE_OVERHEAT_LIMIT) begin
         rd_data = remote_overheat_limit_r;
      end else if (ptr_r == `OFS_LOCAL_CRITICAL_LIMIT) begin
         rd_data = local_critical_limit_r;
      end else if (ptr_r == `OFS_PASSIVE_COOLING_LIMIT) begin
         rd_data = passive_cooling_limit_r;
      end else if (ptr_r == `OFS_REMOTE_CRITICAL_LIMIT) begin
         rd_data = remote_critical_limit_r;
      end else if (ptr_r == `OFS_FAN_TRAITS) begin
         rd_data = fan_traits_r;
      end else if (ptr_r == `OFS_COOL_DUTY_SETTING) begin
         rd_data = cool_duty_setting_r;
      end else begin
         rd_data = 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Readings, captured once per conversion

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         local_temp_r <= {`RST_TEMP_HIGH_BYTE, 3'h0};
         remote_temp_r <= {`RST_TEMP_HIGH_BYTE, 3'h0};
      end else if (temp_valid_i) begin
         local_temp_r <= local_temp_i;
         remote_temp_r <= remote_temp_i;
      end
   end

   assign local_reading_top_bit = local_temp_r[10];
   assign remote_lower_limit_top_bit = remote_lower_limit_r[7];
   assign cool_duty_top_bit = cool_duty_setting_r[7];

   ////////////////////////////////////////////////////////////////////////////
   // Limit comparisons

   limit_compare u_local_crit (
      .reading_i(local_temp_r),
      .limit_i(local_critical_limit_r),
      .at_or_above_o(local_crit_ge),
      .below_o(unused_lt0)
   );

   limit_compare u_remote_crit (
      .reading_i(remote_temp_r),
      .limit_i(remote_critical_limit_r),
      .at_or_above_o(remote_crit_ge),
      .below_o(unused_lt1)
   );

   limit_compare u_local_hi (
      .reading_i(local_temp_r),
      .limit_i(local_upper_limit_r),
      .at_or_above_o(local_hi_ge),
      .below_o(unused_lt2)
   );

   limit_compare u_local_lo (
      .reading_i(local_temp_r),
      .limit_i(local_lower_limit_r),
      .at_or_above_o(unused_ge0),
      .below_o(local_lo_lt)
   );

   limit_compare u_local_th (
      .reading_i(local_temp_r),
      .limit_i(local_overheat_limit_r),
      .at_or_above_o(local_th_ge),
      .below_o(unused_lt3)
   );

   limit_compare u_remote_hi (
      .reading_i(remote_temp_r),
      .limit_i(remote_upper_limit_r),
      .at_or_above_o(remote_hi_ge),
      .below_o(unused_lt4)
   );

   // Low three bits of the lower limit are zero inside the comparator
   limit_compare u_remote_lo (
      .reading_i(remote_temp_r),
      .limit_i(remote_lower_limit_r),
      .at_or_above_o(unused_ge1),
      .below_o(remote_lo_lt)
   );

   limit_compare u_remote_th (
      .reading_i(remote_temp_r),
      .limit_i(remote_overheat_limit_r),
      .at_or_above_o(remote_th_ge),
      .below_o()
   );

   ////////////////////////////////////////////////////////////////////////////
   // Flags, alert and over-temperature output

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         local_critical_flag_o <= 1'b0;
         remote_critical_flag_o <= 1'b0;
         overtemp_output_n_o <= 1'b1;
         local_out_of_range_o <= 1'b0;
         remote_out_of_range_o <= 1'b0;
         local_overheat_o <= 1'b0;
         remote_overheat_o <= 1'b0;
      end else begin
         // Set beats clear so an event in the clearing cycle is kept
         local_critical_flag_o <= local_crit_ge | (local_critical_flag_o & ~flag_clear_i);
         remote_critical_flag_o <= remote_crit_ge |
            (remote_critical_flag_o & ~flag_clear_i);
         // Follows the live comparison, not the sticky flags
         overtemp_output_n_o <= ~(local_crit_ge | remote_crit_ge);
         local_out_of_range_o <= local_hi_ge | local_lo_lt;
         remote_out_of_range_o <= remote_hi_ge | remote_lo_lt;
         local_overheat_o <= local_th_ge;
         remote_overheat_o <= remote_th_ge;
      end
   end

   // Masks gate only the pin, never the flags
   assign alert_o = 1'b0;
   assign alert_oe_n_o = ~(global_int_en_i &
      ((local_critical_flag_o & local_crit_int_en_i) |
       (remote_critical_flag_o & remote_crit_int_en_i)));

   ////////////////////////////////////////////////////////////////////////////
   // Duty selection and fan settings

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         duty_value_o <= `RST_COOL_DUTY_SETTING;
      end else if (auto_fan_mode_i && cool_zone_i) begin
         duty_value_o <= cool_duty_setting_r;
      end else begin
         duty_value_o <= loop_duty_i;
      end
   end

   assign passive_cooling_o = passive_cooling_limit_r[5:0];
   assign spin_disable_o = fan_traits_r[`SPIN_DISABLE_BIT];
   assign pwm_freq_sel_o = fan_traits_r[`PWM_FREQ_MSB:`PWM_FREQ_LSB];
   assign spinup_time_o = fan_traits_r[`SPINUP_TIME_MSB:`SPINUP_TIME_LSB];

endmodule

// ---- test/fan_bank_props.sv ----
`timescale 1ns/1ns
module fan_bank_checker (
   input wire clk_i,
   input wire arst_n_i,
   input wire flag_clear_i,
   input wire global_int_en_i,
   input wire local_crit_int_en_i,
   input wire remote_crit_int_en_i,
   input wire auto_fan_mode_i,
   input wire cool_zone_i,
   input wire [7:0] loop_duty_i,
   input wire [7:0] duty_value_o,
   input wire local_critical_flag_o,
   input wire remote_critical_flag_o,
   input wire overtemp_output_n_o,
   input wire alert_oe_n_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   // Flags are sticky until an explicit clear
   sequence s_local_held;
      arst_n_i && local_critical_flag_o && !flag_clear_i;
   endsequence
   sequence s_remote_held;
      arst_n_i && remote_critical_flag_o && !flag_clear_i;
   endsequence
   a_overtemp_cause: assert property (
      !overtemp_output_n_o |-> local_critical_flag_o || remote_critical_flag_o)
      else $error("overtemp low with no critical flag");
   a_local_sticky: assert property (
      s_local_held |=> local_critical_flag_o) else $error("local flag dropped");
   a_remote_sticky: assert property (
      s_remote_held |=> remote_critical_flag_o) else $error("remote flag dropped");
   a_local_rise: assert property (
      $rose(local_critical_flag_o) |-> !overtemp_output_n_o)
      else $error("local flag rose without overtemp");
   a_remote_rise: assert property (
      $rose(remote_critical_flag_o) |-> !overtemp_output_n_o)
      else $error("remote flag rose without overtemp");
   a_alert_local: assert property (
      local_critical_flag_o && global_int_en_i && local_crit_int_en_i |-> !alert_oe_n_o)
      else $error("alert missing for local flag");
   a_alert_masked: assert property (
      !alert_oe_n_o |-> global_int_en_i && ((local_critical_flag_o && local_crit_int_en_i)
      || (remote_critical_flag_o && remote_crit_int_en_i))) else $error("alert not masked");
   a_duty_loop: assert property (
      arst_n_i && !(auto_fan_mode_i && cool_zone_i) |=> duty_value_o == $past(loop_duty_i))
      else $error("duty not following loop");
endmodule

bind temp_limit_fan_register_bank fan_bank_checker fan_bank_checker_i (.clk_i, .arst_n_i,
   .flag_clear_i, .global_int_en_i, .local_crit_int_en_i, .remote_crit_int_en_i,
   .auto_fan_mode_i, .cool_zone_i, .loop_duty_i, .duty_value_o, .local_critical_flag_o,
   .remote_critical_flag_o, .overtemp_output_n_o, .alert_oe_n_o);

// ---- test/smbus_host_model.sv ----
`timescale 1ns/1ns
module smbus_host_model (
   input wire clk_i,
   input wire sda_line_i,
   output logic scl_o,
   output logic sda_o
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // Half period well above the device's sync lag
   task automatic put(input logic s, input logic c);
      scl_o <= c;
      sda_o <= s;
      repeat (10) @(posedge clk_i);
   endtask
   // SDA moves only while SCL is low, else a false start or stop
   task automatic start();
      put(sda_o, 1'b0);
      put(1'b1, 1'b0);
      put(1'b1, 1'b1);
      put(1'b0, 1'b1);
      put(1'b0, 1'b0);
   endtask
   task automatic stop();
      put(sda_o, 1'b0);
      put(1'b0, 1'b0);
      put(1'b0, 1'b1);
      put(1'b1, 1'b1);
   endtask
   task automatic bit_io(input logic b, output logic r);
      put(sda_o, 1'b0);
      put(b, 1'b0);
      put(b, 1'b1);
      r = sda_line_i;
   endtask
   // Byte out MSB first, then the ninth (acknowledge) bit
   task automatic byte_io(input logic [7:0] tx, input logic ak, output logic [7:0] rx,
      output logic a);
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      bit_io(ak, a);
   endtask
   task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d, output logic ok);
      logic [7:0] rx;
      logic a0, a1, a2;
      start();
      byte_io(8'h30, 1'b1, rx, a0);
      byte_io(ptr, 1'b1, rx, a1);
      byte_io(d, 1'b1, rx, a2);
      stop();
      ok = (a0 === 1'b0) && (a1 === 1'b0) && (a2 === 1'b0);
   endtask
   task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
      logic [7:0] rx;
      logic a0, a1, a2, na;
      start();
      byte_io(8'h30, 1'b1, rx, a0);
      byte_io(ptr, 1'b1, rx, a1);
      start();
      byte_io(8'h31, 1'b1, rx, a2);
      byte_io(8'hff, 1'b1, d, na);
      stop();
      ok = (a0 === 1'b0) && (a1 === 1'b0) && (a2 === 1'b0);
   endtask
endmodule

// ---- test/test_temp_limit_fan_register_bank.sv ----
`timescale 1ns/1ns
module test_temp_limit_fan_register_bank;
   logic clk_i = 1'b0, arst_n_i = 1'b0, temp_valid_i = 1'b0, flag_clear_i = 1'b0;
   logic global_int_en_i = 1'b1, local_crit_int_en_i = 1'b1, remote_crit_int_en_i = 1'b1;
   logic auto_fan_mode_i = 1'b0, cool_zone_i = 1'b0;
   logic [7:0] loop_duty_i = 8'h00;
   logic [10:0] local_temp_i = 11'h100, remote_temp_i = 11'h100;
   wire scl, host_sda, sda_o, sda_oe_n_o, alert_oe_n_o, local_critical_flag_o;
   wire remote_critical_flag_o, overtemp_output_n_o, remote_out_of_range_o;
   wire [7:0] duty_value_o;
   // Open-drain line with pull-up
   wire sda_line = host_sda & (sda_oe_n_o | sda_o);
   int fails = 0, num_checks = 0;
   logic ok;
   logic [7:0] rd;

   initial forever #10 clk_i = ~clk_i;

   smbus_host_model smbus_host_model_i (.clk_i(clk_i), .sda_line_i(sda_line), .scl_o(scl),
      .sda_o(host_sda));
   temp_limit_fan_register_bank temp_limit_fan_register_bank_i (.clk_i(clk_i),
      .arst_n_i(arst_n_i), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
      .sda_oe_n_o(sda_oe_n_o), .alert_i(1'b1), .alert_o(), .alert_oe_n_o(alert_oe_n_o),
      .local_temp_i(local_temp_i), .remote_temp_i(remote_temp_i),
      .temp_valid_i(temp_valid_i), .global_int_en_i(global_int_en_i),
      .local_crit_int_en_i(local_crit_int_en_i), .remote_crit_int_en_i(remote_crit_int_en_i),
      .flag_clear_i(flag_clear_i), .auto_fan_mode_i(auto_fan_mode_i),
      .cool_zone_i(cool_zone_i), .loop_duty_i(loop_duty_i), .duty_value_o(duty_value_o),
      .local_critical_flag_o(local_critical_flag_o),
      .remote_critical_flag_o(remote_critical_flag_o),
      .overtemp_output_n_o(overtemp_output_n_o), .local_out_of_range_o(),
      .remote_out_of_range_o(remote_out_of_range_o), .local_overheat_o(),
      .remote_overheat_o(), .passive_cooling_o(), .spin_disable_o(), .pwm_freq_sel_o(),
      .spinup_time_o());

   task automatic report_and_stop();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check_bit(input string what, input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp);
      smbus_host_model_i.read_reg(ptr, rd, ok);
      check_bit("read ack", 1'b1, ok);
      check_byte($sformatf("register %h", ptr), exp, rd);
   endtask
   task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
      smbus_host_model_i.write_reg(ptr, d, ok);
      check_bit("write ack", 1'b1, ok);
   endtask
   // Readings land at the valid edge, flags one edge later
   task automatic apply(input logic [10:0] l, input logic [10:0] r);
      @(posedge clk_i);
      local_temp_i <= l;
      remote_temp_i <= r;
      temp_valid_i <= 1'b1;
      @(posedge clk_i);
      temp_valid_i <= 1'b0;
      @(posedge clk_i);
      @(negedge clk_i);
   endtask

   task automatic t_reset_values();
      logic [7:0] ofs[13] = '{8'h0a, 8'h0b, 8'h14, 8'h15, 8'h16, 8'h18, 8'h19, 8'h1a, 8'h1b,
         8'h1c, 8'h1d, 8'h20, 8'h21};
      logic [7:0] rst[13] = '{8'h80, 8'h80, 8'h3c, 8'h00, 8'h46, 8'h50, 8'h00, 8'h64, 8'h50,
         8'h00, 8'h69, 8'h1d, 8'h55};
      for (int i = 0; i < 13; i++) begin
         rd_chk(ofs[i], rst[i]);
      end
   endtask
   task automatic t_reserved_and_ro();
      wr(8'h17, 8'ha5);
      rd_chk(8'h17, 8'h00);
      wr(8'h0a, 8'h11);
      rd_chk(8'h0a, 8'h80);
   endtask
   task automatic t_readings();
      apply(11'h1a5, 11'h1ff);
      rd_chk(8'h0a, 8'h34);
      rd_chk(8'h0b, 8'h3f);
   endtask
   task automatic t_remote_lower();
      wr(8'h19, 8'ha5);
      rd_chk(8'h19, 8'ha5);
      wr(8'h19, 8'h02);
      apply(11'h100, 11'd15);
      check_bit("remote below lower", 1'b1, remote_out_of_range_o);
      apply(11'h100, 11'd16);
      check_bit("remote at lower", 1'b0, remote_out_of_range_o);
   endtask
   task automatic t_critical(input logic rem);
      logic [10:0] lim;
      lim = rem ? 11'h348 : 11'h280;
      apply(rem ? 11'h100 : lim - 11'd1, rem ? lim - 11'd1 : 11'h100);
      check_bit("flag below", 1'b0, rem ? remote_critical_flag_o : local_critical_flag_o);
      check_bit("overtemp below", 1'b1, overtemp_output_n_o);
      apply(rem ? 11'h100 : lim, rem ? lim : 11'h100);
      check_bit("flag at limit", 1'b1, rem ? remote_critical_flag_o : local_critical_flag_o);
      check_bit("overtemp at limit", 1'b0, overtemp_output_n_o);
      check_bit("alert at limit", 1'b0, alert_oe_n_o);
      @(posedge clk_i);
      local_crit_int_en_i <= 1'b0;
      remote_crit_int_en_i <= 1'b0;
      @(negedge clk_i);
      check_bit("alert masked", 1'b1, alert_oe_n_o);
      check_bit("flag masked", 1'b1, rem ? remote_critical_flag_o : local_critical_flag_o);
      apply(11'h100, 11'h100);
      check_bit("overtemp cooled", 1'b1, overtemp_output_n_o);
      @(posedge clk_i);
      flag_clear_i <= 1'b1;
      local_crit_int_en_i <= 1'b1;
      remote_crit_int_en_i <= 1'b1;
      @(posedge clk_i);
      flag_clear_i <= 1'b0;
      @(negedge clk_i);
      check_bit("flag cleared", 1'b0, rem ? remote_critical_flag_o : local_critical_flag_o);
   endtask
   task automatic t_cool_duty();
      @(posedge clk_i);
      auto_fan_mode_i <= 1'b1;
      cool_zone_i <= 1'b1;
      loop_duty_i <= 8'hc3;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      check_byte("cool duty", 8'h55, duty_value_o);
      wr(8'h21, 8'h3c);
      check_byte("cool duty new", 8'h3c, duty_value_o);
      @(posedge clk_i);
      cool_zone_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      check_byte("loop duty", 8'hc3, duty_value_o);
   endtask

   initial begin
      repeat (100000) @(posedge clk_i);
      fails++;
      report_and_stop();
   end
   initial begin
      repeat (20) @(posedge clk_i);
      arst_n_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      t_reset_values();
      t_reserved_and_ro();
      t_readings();
      t_remote_lower();
      t_critical(1'b0);
      t_critical(1'b1);
      t_cool_duty();
      report_and_stop();
   end
endmodule
